// ### dv/ppcs_regs_asserts.sv
/*
  Concurrent checks on the ports of the control and status register bank.
  Assumes binding onto ppcs_regs with the core clock and its sync reset.
*/
`timescale 1ns/1ps
module ppcs_regs_asserts
  import ppcs_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [3:0] proc_number,
  input wire logic fetch_ok,
  input wire logic loop_load,
  input wire logic int_load,
  input wire logic alu_wr,
  input wire logic gu_wr,
  input wire logic lu_wr,
  input wire logic unhalt,
  input wire logic int_enable_op,
  input wire logic int_disable_op,
  input wire logic sp_push,
  input wire logic sp_pop,
  input wire logic int_entry,
  input wire logic flag_op,
  input wire ppcs_flagmode_e flag_mode,
  input wire logic [6:0] rd_code,
  input wire logic [15:0] int_pending,
  input wire logic [15:0] int_mask,
  input wire logic [31:0] program_counter,
  input wire logic [31:0] stack_pointer,
  input wire logic [31:0] alu_status,
  input wire logic [31:0] rd_data,
  input wire logic gie,
  input wire logic loop_inhibit,
  input wire logic loop_enable,
  input wire logic [15:0] int_recognised,
  input wire logic push_valid
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  logic quiet_pc;
  logic quiet_units;
  assign quiet_pc = !int_load && !loop_load && !alu_wr && !gu_wr;
  assign quiet_units = !gu_wr && !lu_wr;
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence entry_burst;
    ##2 push_valid [*4] ##1 !push_valid;
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  pc_reserved_a: assert property (program_counter[2] == 1'b0)
    else $error("fetch pointer bit 2 set");
  sr_reserved_a: assert property (alu_status[27:9] == 19'h0)
    else $error("unused status bits set");
  sp_align_a: assert property (stack_pointer[1:0] == 2'h0)
    else $error("stack pointer misaligned");
  fetch_step_a: assert property (fetch_ok && quiet_pc |=>
    program_counter[31:3] == $past(program_counter[31:3]) + 29'h1)
    else $error("fetch counter did not step");
  gie_set_a: assert property (int_enable_op && !int_disable_op &&
    !unhalt && !gu_wr |=> gie) else $error("enable op missed");
  gie_clear_a: assert property (int_disable_op && !int_enable_op &&
    !unhalt && !gu_wr |=> !gie) else $error("disable op missed");
  int_gate_a: assert property (int_recognised ==
    (gie ? (int_pending & int_mask) : 16'h0))
    else $error("interrupt gating wrong");
  loop_gate_a: assert property (loop_enable != loop_inhibit)
    else $error("loop enable not inverse of inhibit");
  sp_push_a: assert property (sp_push && !sp_pop && quiet_units |=>
    stack_pointer == $past(stack_pointer) - 32'h4)
    else $error("push did not predecrement");
  sp_pop_a: assert property (sp_pop && !sp_push && quiet_units &&
    !int_entry && !$past(int_entry) && !push_valid |=>
    stack_pointer == $past(stack_pointer) + 32'h4)
    else $error("pop did not postincrement");
  entry_push_a: assert property (int_entry |-> entry_burst)
    else $error("entry push burst wrong");
  pc_read_a: assert property (rd_code == CODE_PC_READ |=>
    rd_data == $past(program_counter)) else $error("pc read wrong");
  mult_keep_a: assert property (flag_op && flag_mode == FM_MULT &&
    !alu_wr && quiet_units |=> $stable(alu_status[31:28]))
    else $error("multiply changed flags");
  sp_reset_a: assert property (disable iff (1'b0)
    !rstn ##1 rstn |-> stack_pointer ==
    (SP_RESET_BASE | {16'h0, proc_number, 12'h0}))
    else $error("stack pointer reset value wrong");
endmodule // ppcs_regs_asserts

// ### dv/ppcs_stack_mem.sv
/*
  Stack memory model: captures the words of the interrupt entry push.
  Assumes push_valid is a registered strobe on the core clock.
*/
`timescale 1ns/1ps
module ppcs_stack_mem (
  input wire logic clock,
  input wire logic mem_clr,
  input wire logic push_valid,
  input wire logic [31:0] push_addr,
  input wire logic [31:0] push_data,
  output logic [31:0] cap_addr [4],
  output logic [31:0] cap_data [4],
  output int cap_n
);
  always @(posedge clock) begin
    if (mem_clr) begin
      cap_n <= 0;
    end else if (push_valid && cap_n < 4) begin
      cap_addr[cap_n] <= push_addr;
      cap_data[cap_n] <= push_data;
      cap_n <= cap_n + 1;
    end
  end
endmodule // ppcs_stack_mem

// ### dv/tb_pp_control_status_registers.sv
/*
  Self-checking bench for the control and status register bank.
  Assumes ppcs_regs, the checker and the stack memory model are compiled.
*/
`timescale 1ns/1ps
module tb_pp_control_status_registers;
  import ppcs_pkg::*;
  logic clock, rstn, unhalt, fetch_ok, loop_load, int_load, int_enable_op;
  logic int_disable_op, reti_inhibit_set, reti_inhibit_clr, alu_wr;
  logic alu_cond_ok, gu_wr, gu_imm_unscaled, lu_wr, sp_push, sp_pop;
  logic int_entry, flag_op, carry_in31, carry_out31, rot_in31, push_valid;
  logic gie, loop_inhibit, loop_enable, mem_clr;
  logic [1:0] task_vector_ctl, gu_offset_low;
  logic [3:0] proc_number, flag_protect, split_carry, split_zero, split_used;
  logic [6:0] alu_wr_code, rd_code, gu_wr_code, lu_wr_code;
  logic [15:0] int_pending, int_mask, int_recognised;
  logic [28:0] loop_target, int_target, ipa_value, ipe_value;
  logic [31:0] alu_wr_data, rd_data, gu_wr_data, lu_wr_data, push_addr;
  logic [31:0] push_data, alu_result, detect_src, program_counter;
  logic [31:0] stack_pointer, alu_status, return_address;
  logic [31:0] cap_addr [4];
  logic [31:0] cap_data [4];
  int cap_n;
  ppcs_flagmode_e flag_mode;
  ppcs_detect_e det_kind;
  ppcs_mss_e flag_source_select;
  int n_errors = 0;
  int check_count = 0;
  ppcs_regs ppcs_regs_inst (.*);
  ppcs_stack_mem ppcs_stack_mem_inst (.*);
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step();
    s = 1'b0;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input int u, input logic [6:0] c, input logic [31:0] d);
    alu_cond_ok = 1'b1;
    {alu_wr_code, gu_wr_code, lu_wr_code} = {c, c, c};
    {alu_wr_data, gu_wr_data, lu_wr_data} = {d, d, d};
    alu_wr = (u == 0);
    gu_wr = (u == 1);
    lu_wr = (u == 2);
    step();
    {alu_wr, gu_wr, lu_wr} = 3'b000;
  endtask
  task automatic flag(input ppcs_flagmode_e m, input logic [31:0] res,
    input logic [1:0] cc, input logic [3:0] sc, input logic [3:0] sz,
    input logic [3:0] exp);
    flag_mode = m;
    alu_result = res;
    {carry_in31, carry_out31} = cc;
    split_carry = sc;
    split_zero = sz;
    pulse(flag_op);
    chk({28'h0, alu_status[31:28]}, {28'h0, exp});
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_pc();
    chk(program_counter, 32'h0);
    chk(stack_pointer, 32'h0100_57f0);
    wr(0, CODE_CALL, 32'h0000_1237);
    chk(program_counter, 32'h0000_1230);
    chk(return_address, 32'h0000_0008);
    wr(0, CODE_PLAIN_JUMP, 32'h0000_2000);
    chk(return_address, 32'h0000_0008);
    pulse(fetch_ok);
    chk(program_counter, 32'h0000_2008);
    fetch_ok = 1'b1;
    wr(0, CODE_PLAIN_JUMP, 32'h0000_3000);
    fetch_ok = 1'b0;
    chk(program_counter, 32'h0000_3000);
    int_target = 29'h0000_0200;
    pulse(int_load);
    chk(program_counter, 32'h0000_1000);
    rd_code = CODE_PC_READ;
    step();
    chk(rd_data, 32'h0000_1000);
    $display("test pc done");
  endtask
  task automatic test_intctl();
    task_vector_ctl = 2'b10;
    pulse(unhalt);
    chk(gie, 1'b1);
    chk(loop_inhibit, 1'b0);
    int_pending = 16'h00f0;
    int_mask = 16'h0030;
    step();
    chk(int_recognised, 16'h0030);
    pulse(int_disable_op);
    chk(int_recognised, 16'h0);
    pulse(int_enable_op);
    chk(gie, 1'b1);
    gu_imm_unscaled = 1'b1;
    gu_offset_low = 2'b01;
    wr(1, CODE_PLAIN_JUMP, 32'h0000_5001);
    gu_imm_unscaled = 1'b0;
    chk({gie, loop_inhibit}, 2'b11);
    chk(program_counter, 32'h0000_5003);
    loop_target = 29'h0000_0100;
    pulse(loop_load);
    chk(program_counter, 32'h0000_5003);
    chk(loop_enable, 1'b0);
    pulse(reti_inhibit_clr);
    pulse(loop_load);
    chk(program_counter, 32'h0000_0802);
    pulse(reti_inhibit_set);
    chk(loop_inhibit, 1'b1);
    pulse(reti_inhibit_clr);
    $display("test intctl done");
  endtask
  task automatic test_stack();
    wr(1, CODE_GLOBAL_STACK, 32'h0000_3003);
    chk(stack_pointer, 32'h0000_3000);
    wr(2, CODE_LOCAL_STACK, 32'h0000_4002);
    chk(stack_pointer, 32'h0000_4000);
    pulse(sp_push);
    chk(stack_pointer, 32'h0000_3ffc);
    pulse(sp_pop);
    rd_code = CODE_GLOBAL_STACK;
    step();
    chk(rd_data, 32'h0000_4000);
    pulse(mem_clr);
    pulse(int_entry);
    for (int i = 0; i < 20 && cap_n < 4; i++) begin
      step();
    end
    if (cap_n < 4) begin
      chk(cap_n, 4);
      conclude();
    end
    for (int i = 1; i < 4; i++) begin
      chk(cap_addr[i], cap_addr[0] - 32'h4 * i);
    end
    chk(cap_addr[0], 32'h0000_3ffc);
    chk(cap_data[0], 32'h0000_0802);
    chk(cap_data[1], 32'h0000_0088);
    chk(cap_data[2], 32'h0000_0110);
    chk(cap_data[3], 32'h0);
    chk(stack_pointer, 32'h0000_3ff0);
    $display("test stack done");
  endtask
  task automatic test_flags();
    ppcs_detect_e kinds [4];
    kinds = '{DET_LMO, DET_RMO, DET_LMBC, DET_RMBC};
    flag(FM_NORMAL, 32'h8000_0000, 2'b01, 4'h0, 4'h0, 4'b1110);
    flag(FM_NORMAL, 32'h0, 2'b11, 4'h0, 4'h0, 4'b0101);
    flag(FM_BOOL, 32'h0, 2'b01, 4'h0, 4'h0, 4'b0001);
    flag(FM_SPLIT, 32'h1, 2'b00, 4'hf, 4'h3, 4'b0111);
    foreach (kinds[i]) begin
      det_kind = kinds[i];
      flag(FM_DETECT, 32'h0, 2'b00, 4'h0, 4'h0, 4'b0010);
    end
    detect_src = 32'h0000_0010;
    det_kind = DET_LMO;
    flag(FM_DETECT, 32'h0, 2'b00, 4'h0, 4'h0, 4'b0000);
    flag(FM_NORMAL, 32'h8000_0000, 2'b01, 4'h0, 4'h0, 4'b1110);
    flag(FM_MULT, 32'h0, 2'b11, 4'hf, 4'hf, 4'b1110);
    rot_in31 = 1'b1;
    flag(FM_DIVIDE, 32'h0, 2'b00, 4'h0, 4'h0, 4'b1001);
    flag_protect = 4'b1000;
    flag(FM_NORMAL, 32'h0, 2'b11, 4'h0, 4'h0, 4'b1101);
    flag_protect = 4'h0;
    flag_op = 1'b1;
    wr(0, CODE_PLAIN_JUMP, 32'h0000_0800);
    chk({28'h0, alu_status[31:28]}, 32'hd);
    wr(1, CODE_STATUS, 32'hffff_ffff);
    flag_op = 1'b0;
    chk(alu_status, 32'hf000_01ff);
    for (int i = 0; i < 4; i++) begin
      wr(2, CODE_STATUS, {23'h0, i[1:0], 7'h55});
      chk(alu_status, {23'h0, i[1:0], 7'h55});
      chk(flag_source_select, i[1:0]);
    end
    rd_code = CODE_STATUS;
    step();
    chk(rd_data, 32'h0000_01d5);
    $display("test flags done");
  endtask
  // ----------------------------------------------------------------
  // Clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    {unhalt, fetch_ok, loop_load, int_load, int_enable_op, int_disable_op,
     reti_inhibit_set, reti_inhibit_clr, alu_wr, alu_cond_ok, gu_wr,
     gu_imm_unscaled, lu_wr, sp_push, sp_pop, int_entry, flag_op,
     carry_in31, carry_out31, rot_in31, mem_clr, rstn} = '0;
    {task_vector_ctl, gu_offset_low, flag_protect, split_carry, split_zero,
     alu_wr_code, rd_code, gu_wr_code, lu_wr_code, int_pending, int_mask,
     loop_target, int_target, alu_wr_data, gu_wr_data, lu_wr_data,
     alu_result, detect_src} = '0;
    split_used = 4'hf;
    proc_number = 4'h5;
    ipa_value = 29'h0000_0011;
    ipe_value = 29'h0000_0022;
    flag_mode = FM_NORMAL;
    det_kind = DET_LMO;
    repeat (5) @(posedge clock);
    #1;
    rstn = 1'b1;
    test_pc();
    test_intctl();
    test_stack();
    test_flags();
    conclude();
  end
endmodule // tb_pp_control_status_registers
bind ppcs_regs ppcs_regs_asserts ppcs_regs_asserts_inst (.*);

// ### hdl/ppcs_flags.sv
/*
  Computes the next negative, carry, overflow and zero flags for one ALU op.
  Assumes the ALU supplies its result, carries and split compare vectors.
*/
`timescale 1ns/1ps
module ppcs_flags
  import ppcs_pkg::*;
(
  input wire ppcs_flagmode_e mode,
  input wire ppcs_detect_e det_kind,
  input wire logic [31:0] result,
  input wire logic [31:0] detect_src,
  input wire logic carry_in31,
  input wire logic carry_out31,
  input wire logic rot_in31,
  input wire logic [3:0] split_carry,
  input wire logic [3:0] split_zero,
  input wire logic [3:0] split_used,
  output logic [3:0] flags
);
  logic n, c, v, z;
  logic [3:0] zc, cc, zca;
  always_comb begin
    zc = split_zero & split_used;
    zca = split_zero | ~split_used;
    cc = split_carry & split_used;
    n = result[31];
    c = carry_out31;
    v = carry_in31 ^ carry_out31;
    z = (result == 32'h0000_0000);
    case (mode)
      FM_BOOL: begin
        c = 1'b0;
        v = 1'b0;
      end
      FM_SPLIT: begin
        n = &zca;
        c = |cc;
        v = &(split_carry | ~split_used);
        z = |zc;
      end
      FM_DETECT: begin
        n = &zca;
        c = |cc;
        z = |zc;
        case (det_kind)
          DET_LMO, DET_RMO: v = (detect_src == 32'h0000_0000);
          default: v = (&detect_src) | ~(|detect_src);
        endcase
      end
      FM_DIVIDE: n = carry_out31 | rot_in31;
      default: ;
    endcase
    flags = {n, c, v, z};
  end
endmodule // ppcs_flags

// ### hdl/ppcs_intctl.sv
/*
  Interrupt-enable and loop-inhibit control bits of the fetch pointer.
  Assumes one-cycle operation strobes from the pipeline on the core clock.
*/
`timescale 1ns/1ps
module ppcs_intctl
  import ppcs_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic unhalt,
  input wire logic [1:0] task_vector_ctl,
  input wire logic int_enable_op,
  input wire logic int_disable_op,
  input wire logic ctl_load,
  input wire logic [1:0] ctl_load_sel,
  input wire logic [1:0] ctl_load_val,
  input wire logic reti_inhibit_set,
  input wire logic reti_inhibit_clr,
  input wire logic [15:0] int_pending,
  input wire logic [15:0] int_mask,
  output logic gie,
  output logic loop_inhibit,
  output logic [15:0] int_recognised
);
  // ---------------------------------------------------------------
  // Interrupt enable
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      gie <= 1'b0;
    end else if (unhalt) begin
      gie <= task_vector_ctl[PC_GIE];
    end else if (int_enable_op) begin
      gie <= 1'b1;
    end else if (int_disable_op) begin
      gie <= 1'b0;
    end else if (ctl_load && ctl_load_sel[PC_GIE]) begin
      gie <= ctl_load_val[PC_GIE];
    end
  end

  // ---------------------------------------------------------------
  // Loop inhibit
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      loop_inhibit <= 1'b0;
    end else if (unhalt) begin
      loop_inhibit <= task_vector_ctl[PC_LINH];
    end else if (ctl_load && ctl_load_sel[PC_LINH]) begin
      loop_inhibit <= ctl_load_val[PC_LINH];
    end else if (reti_inhibit_set) begin
      loop_inhibit <= 1'b1;
    end else if (reti_inhibit_clr) begin
      loop_inhibit <= 1'b0;
    end
  end

  assign int_recognised = gie ? (int_pending & int_mask) : 16'h0000;
endmodule // ppcs_intctl

// ### hdl/ppcs_pkg.sv
/*
  Package for the control and status register bank of a parallel DSP core:
  register codes, field positions, reset values and flag-mode enumerations.
  Assumes the core presents 7-bit register codes from its ALU and units.
*/
package ppcs_pkg;
  localparam logic [6:0] CODE_PC_READ = 7'h38;
  localparam logic [6:0] CODE_CALL = 7'h38;
  localparam logic [6:0] CODE_PLAIN_JUMP = 7'h39;
  localparam logic [6:0] CODE_LOCAL_STACK = 7'h06;
  localparam logic [6:0] CODE_GLOBAL_STACK = 7'h0e;
  localparam logic [6:0] CODE_STATUS = 7'h29;
  localparam int PC_CNT_LSB = 3;
  localparam int PC_GIE = 1;
  localparam int PC_LINH = 0;
  localparam int SR_N = 31;
  localparam int SR_C = 30;
  localparam int SR_V = 29;
  localparam int SR_Z = 28;
  localparam logic [31:0] SR_WMASK = 32'hf000_01ff;
  localparam logic [31:0] PC_WMASK = 32'hffff_fff8;
  localparam logic [31:0] SP_WMASK = 32'hffff_fffc;
  localparam logic [31:0] SP_RESET_BASE = 32'h0100_07f0;
  localparam int SP_PNUM_LSB = 12;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [31:0] SR_RESET = 32'h0000_0000;
  localparam logic [28:0] PC_STEP = 29'h0000_0001;
  typedef enum logic [2:0] {
    FM_NORMAL = 3'h0, FM_BOOL = 3'h1, FM_SPLIT = 3'h3,
    FM_DETECT = 3'h2, FM_DIVIDE = 3'h6, FM_MULT = 3'h7
  } ppcs_flagmode_e;
  typedef enum logic [1:0] {
    DET_LMO = 2'h0, DET_RMO = 2'h1, DET_LMBC = 2'h3, DET_RMBC = 2'h2
  } ppcs_detect_e;
  typedef enum logic [1:0] {
    MSS_ZERO = 2'h0, MSS_SIGN = 2'h1, MSS_EXT = 2'h2, MSS_RSVD = 2'h3
  } ppcs_mss_e;
endpackage

// ### hdl/ppcs_regs.sv
/*
  Control and status register bank: fetch pointer, shared stack pointer and
  ALU status register, reached by register codes from the ALU, the global
  and local address units, plus the interrupt entry push sequence.
  Assumes same-cycle strobes from the core pipeline; the assembler keeps
  both units from modifying the stack pointer in one instruction.
*/
`timescale 1ns/1ps
module ppcs_regs
  import ppcs_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [3:0] proc_number,
  input wire logic unhalt,
  input wire logic [1:0] task_vector_ctl,
  input wire logic fetch_ok,
  input wire logic loop_load,
  input wire logic [28:0] loop_target,
  input wire logic int_load,
  input wire logic [28:0] int_target,
  input wire logic int_enable_op,
  input wire logic int_disable_op,
  input wire logic reti_inhibit_set,
  input wire logic reti_inhibit_clr,
  input wire logic [15:0] int_pending,
  input wire logic [15:0] int_mask,
  input wire logic alu_wr,
  input wire logic [6:0] alu_wr_code,
  input wire logic [31:0] alu_wr_data,
  input wire logic alu_cond_ok,
  input wire logic [6:0] rd_code,
  output logic [31:0] rd_data,
  input wire logic gu_wr,
  input wire logic [6:0] gu_wr_code,
  input wire logic [31:0] gu_wr_data,
  input wire logic gu_imm_unscaled,
  input wire logic [1:0] gu_offset_low,
  input wire logic lu_wr,
  input wire logic [6:0] lu_wr_code,
  input wire logic [31:0] lu_wr_data,
  input wire logic sp_push,
  input wire logic sp_pop,
  input wire logic [28:0] ipa_value,
  input wire logic [28:0] ipe_value,
  input wire logic int_entry,
  output logic push_valid,
  output logic [31:0] push_addr,
  output logic [31:0] push_data,
  input wire logic flag_op,
  input wire ppcs_flagmode_e flag_mode,
  input wire ppcs_detect_e det_kind,
  input wire logic [3:0] flag_protect,
  input wire logic [31:0] alu_result,
  input wire logic [31:0] detect_src,
  input wire logic carry_in31,
  input wire logic carry_out31,
  input wire logic rot_in31,
  input wire logic [3:0] split_carry,
  input wire logic [3:0] split_zero,
  input wire logic [3:0] split_used,
  output logic [31:0] program_counter,
  output logic [31:0] stack_pointer,
  output logic [31:0] alu_status,
  output logic [31:0] return_address,
  output logic gie,
  output logic loop_inhibit,
  output logic loop_enable,
  output logic [15:0] int_recognised,
  output ppcs_mss_e flag_source_select
);
  typedef enum logic [2:0] {
    PS_IDLE = 3'h0, PS_PC = 3'h1, PS_IPA = 3'h3, PS_IPE = 3'h2,
    PS_SR = 3'h6
  } ppcs_push_e;

  function automatic logic hits(input logic wr, input logic [6:0] code,
                                input logic [6:0] want);
    hits = wr && (code == want);
  endfunction

  // Counter step, shared by the fetch path and the return address
  function automatic logic [28:0] count_up(input logic [28:0] cnt);
    count_up = cnt + PC_STEP;
  endfunction

  // Word step down, shared by pushes and the push address
  function automatic logic [31:0] word_down(input logic [31:0] addr);
    word_down = addr - WORD_STEP;
  endfunction

  logic [28:0] pc_cnt;
  logic call_wr, jump_wr, gu_pc_wr, st_wr_alu, st_wr_gu, st_wr_lu;
  logic sp_wr_gu, sp_wr_lu, ctl_load;
  logic gu_call_wr;
  logic [31:0] sp_wr_data;
  logic [3:0] new_flags;
  logic [31:0] sr_reg, next_sr;
  logic [31:0] sp_reg, next_sp;
  ppcs_push_e push_state, next_push_state;
  logic [31:0] push_ptr;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  assign call_wr = hits(alu_wr, alu_wr_code, CODE_CALL);
  assign gu_call_wr = hits(gu_wr, gu_wr_code, CODE_CALL);
  assign jump_wr = hits(alu_wr, alu_wr_code, CODE_PLAIN_JUMP);
  assign gu_pc_wr = hits(gu_wr, gu_wr_code, CODE_CALL) ||
                    hits(gu_wr, gu_wr_code, CODE_PLAIN_JUMP);
  assign st_wr_alu = hits(alu_wr, alu_wr_code, CODE_STATUS) && alu_cond_ok;
  assign st_wr_gu = hits(gu_wr, gu_wr_code, CODE_STATUS);
  assign st_wr_lu = hits(lu_wr, lu_wr_code, CODE_STATUS);
  assign sp_wr_gu = hits(gu_wr, gu_wr_code, CODE_GLOBAL_STACK);
  assign sp_wr_lu = hits(lu_wr, lu_wr_code, CODE_LOCAL_STACK);
  // The global unit wins when both units write the pointer
  assign sp_wr_data = sp_wr_gu ? gu_wr_data : lu_wr_data;
  assign ctl_load = gu_pc_wr && gu_imm_unscaled;

  // ---------------------------------------------------------------
  // Fetch counter
  // ---------------------------------------------------------------
  // Replacement sources outrank the fetch step
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pc_cnt <= 29'h0000_0000;
    end else if (int_load) begin
      pc_cnt <= int_target;
    end else if ((call_wr || jump_wr) && alu_cond_ok) begin
      pc_cnt <= alu_wr_data[31:PC_CNT_LSB];
    end else if (gu_pc_wr) begin
      pc_cnt <= gu_wr_data[31:PC_CNT_LSB];
    end else if (loop_load && !loop_inhibit) begin
      pc_cnt <= loop_target;
    end else if (fetch_ok) begin
      pc_cnt <= count_up(pc_cnt);
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      return_address <= 32'h0000_0000;
    end else if ((call_wr && alu_cond_ok) || gu_call_wr) begin
      // Either unit writing the call code saves the return point
      return_address <= {count_up(pc_cnt), 3'h0};
    end
  end

  ppcs_intctl u_intctl (
    .clock(clock),
    .rstn(rstn),
    .unhalt(unhalt),
    .task_vector_ctl(task_vector_ctl),
    .int_enable_op(int_enable_op),
    .int_disable_op(int_disable_op),
    .ctl_load(ctl_load),
    .ctl_load_sel(gu_offset_low),
    .ctl_load_val(gu_wr_data[1:0]),
    .reti_inhibit_set(reti_inhibit_set),
    .reti_inhibit_clr(reti_inhibit_clr),
    .int_pending(int_pending),
    .int_mask(int_mask),
    .gie(gie),
    .loop_inhibit(loop_inhibit),
    .int_recognised(int_recognised)
  );

  assign program_counter = {pc_cnt, 1'b0, gie, loop_inhibit};
  assign loop_enable = ~loop_inhibit;

  // ---------------------------------------------------------------
  // Stack pointer
  // ---------------------------------------------------------------
  always_comb begin
    next_sp = sp_reg;
    // One predecrement per pushed word; none on the entry edge itself
    if (push_state != PS_IDLE) begin
      next_sp = word_down(sp_reg);
    end else if (sp_wr_gu || sp_wr_lu) begin
      next_sp = sp_wr_data;
    end else if (sp_push) begin
      next_sp = word_down(sp_reg);
    end else if (sp_pop) begin
      next_sp = sp_reg + WORD_STEP;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      sp_reg <= SP_RESET_BASE |
                ({28'h0000000, proc_number} << SP_PNUM_LSB);
    end else begin
      sp_reg <= next_sp & SP_WMASK;
    end
  end
  assign stack_pointer = sp_reg & SP_WMASK;
  assign push_ptr = word_down(sp_reg);

  // ---------------------------------------------------------------
  // Interrupt entry push sequence
  // ---------------------------------------------------------------
  always_comb begin
    case (push_state)
      PS_IDLE: next_push_state = int_entry ? PS_PC : PS_IDLE;
      PS_PC: next_push_state = PS_IPA;
      PS_IPA: next_push_state = PS_IPE;
      PS_IPE: next_push_state = PS_SR;
      default: next_push_state = PS_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      push_state <= PS_IDLE;
    end else begin
      push_state <= next_push_state;
    end
  end

  // Strobe and address of each pushed word
  always_ff @(posedge clock) begin
    if (!rstn) begin
      push_valid <= 1'b0;
      push_addr <= 32'h0000_0000;
    end else begin
      push_valid <= (push_state != PS_IDLE);
      push_addr <= push_ptr;
    end
  end

  // Word pushed in each state: pointers first, status last
  always_ff @(posedge clock) begin
    if (!rstn) begin
      push_data <= 32'h0000_0000;
    end else begin
      case (push_state)
        PS_PC: push_data <= program_counter;
        PS_IPA: push_data <= {ipa_value, 3'h0};
        PS_IPE: push_data <= {ipe_value, 3'h0};
        PS_SR: push_data <= sr_reg;
        default: push_data <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Status register
  // ---------------------------------------------------------------
  ppcs_flags u_flags (
    .mode(flag_mode),
    .det_kind(det_kind),
    .result(alu_result),
    .detect_src(detect_src),
    .carry_in31(carry_in31),
    .carry_out31(carry_out31),
    .rot_in31(rot_in31),
    .split_carry(split_carry),
    .split_zero(split_zero),
    .split_used(split_used),
    .flags(new_flags)
  );

  // Protected flags keep their value through explicit writes too
  always_comb begin
    next_sr = sr_reg;
    if (st_wr_alu || st_wr_gu || st_wr_lu) begin
      next_sr = st_wr_gu ? gu_wr_data :
                (st_wr_lu ? lu_wr_data : alu_wr_data);
    end else if (flag_op && alu_cond_ok && !call_wr && !jump_wr &&
                 flag_mode != FM_MULT) begin
      next_sr[SR_Z:SR_Z] = new_flags[0];
      next_sr[SR_V:SR_V] = new_flags[1];
      next_sr[SR_C:SR_C] = new_flags[2];
      next_sr[SR_N:SR_N] = new_flags[3];
    end
    next_sr[SR_N:SR_Z] = (next_sr[SR_N:SR_Z] & ~flag_protect) |
                         (sr_reg[SR_N:SR_Z] & flag_protect);
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      sr_reg <= SR_RESET;
    end else begin
      sr_reg <= next_sr & SR_WMASK;
    end
  end
  assign alu_status = sr_reg;
  assign flag_source_select = ppcs_mss_e'(sr_reg[8:7]);

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  // Registered: data follows its code by one edge
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rd_data <= 32'h0000_0000;
    end else begin
      case (rd_code)
        CODE_PC_READ: rd_data <= program_counter;
        CODE_LOCAL_STACK, CODE_GLOBAL_STACK: rd_data <= stack_pointer;
        CODE_STATUS: rd_data <= sr_reg;
        default: rd_data <= 32'h0000_0000;
      endcase
    end
  end
endmodule // ppcs_regs
